//--- logic/key_matrix_encoder_host_port.sv
/*
  Host-facing logic of a key-matrix encoder: GPIO update and sampling at
  the two-wire acknowledge strobes, port-change interrupt, key code
  encoding with ghost rejection, and the three-wire key code link.
  Assumes an external two-wire slave engine on sys_clk_i that pulses the
  acknowledge strobes, a matrix scanner that reports events with the held
  matrix, and a host that clocks the three-wire link on link_clk_i.
*/
// How it works
// - GPIO outputs change only at write acknowledge
// - Input ports sampled at read address acknowledge
// - Interrupt low when enabled input differs from sample
// - Interrupt released once read address acknowledge resamples inputs
// - Code: release bit, row, column plus one
// - One code per press and per release
// - Rectangle triples report no code
// - Any held keys reported without ghost triples
// - Three-wire link only while link select high
// - Three-wire key event drives interrupt low
// - Code shifted out on host clock rising edges
// - Ninth bit zero, then interrupt returns high
// - Register strobes honoured only while select low
// - Change interrupts masked per port by port_change_irq_enable_i
// - Current code, non-empty and overflow flags readable
`timescale 1ns/1ns
module key_matrix_encoder_host_port #(
  parameter int NUM_ROWS = key_encoder_pkg::NUM_ROWS,
  parameter int NUM_COLS = key_encoder_pkg::NUM_COLS,
  parameter int NUM_PORTS = key_encoder_pkg::NUM_PORTS
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic host_link_select_i,
  input wire logic [19:0] gpio_pin_i,
  output logic [19:0] gpio_pin_o,
  output logic [19:0] gpio_pin_oe_n_o,
  input wire logic [19:0] port_direction_i,
  input wire logic [19:0] port_change_irq_enable_i,
  input wire logic gpio_write_ack_i,
  input wire logic [19:0] gpio_write_data_i,
  input wire logic read_addr_ack_i,
  input wire logic port_input_value_read_i,
  output logic [19:0] port_input_value_o,
  input wire logic key_event_i,
  input wire logic key_release_i,
  input wire logic [2:0] key_row_i,
  input wire logic [3:0] key_col_i,
  input wire logic [95:0] key_matrix_i,
  input wire logic key_code_read_i,
  output logic [7:0] key_code_o,
  output logic key_pending_o,
  output logic key_overflow_o,
  output logic event_irq_n_o,
  input wire logic link_data_i,
  output logic link_data_o,
  output logic link_data_oe_n_o
);
  import key_encoder_pkg::*;

  // Geometry the fixed code layout and port widths can serve
  if (NUM_ROWS > 8 || NUM_COLS > 15 || NUM_ROWS * NUM_COLS > 96 || NUM_PORTS > 20 ||
      NUM_PORTS < 1) begin : g_bad_geometry
    $error("key encoder geometry out of range");
  end

  // True when some pair of rows shares a column and one holds another key
  function automatic logic ghost_triple(input logic [95:0] m);
    logic found;
    logic [14:0] a;
    logic [14:0] b;
    found = 1'b0;
    for (int r1 = 0; r1 < NUM_ROWS; r1++) begin
      for (int r2 = r1 + 1; r2 < NUM_ROWS; r2++) begin
        a = '0;
        b = '0;
        for (int c = 0; c < NUM_COLS; c++) begin
          a[c] = m[r1 * NUM_COLS + c];
          b[c] = m[r2 * NUM_COLS + c];
        end
        // Shared column plus a second column anywhere: triple or full rectangle
        if ((a & b) != 15'h0000 && ((a | b) & ((a | b) - 15'h0001)) != 15'h0000) begin
          found = 1'b1;
        end
      end
    end
    return found;
  endfunction

  typedef struct packed {
    logic [19:0] gpio_s1;
    logic [19:0] gpio_s2;
    logic sel_s1;
    logic sel_s2;
    logic [19:0] pin_out;
    logic [19:0] pin_oe_n;
    logic [19:0] piv;
    logic irq_n;
    logic [7:0] key_code;
    logic key_pending;
    logic key_overflow;
    logic [7:0] link_code;
    logic req_tgl;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic data_oe_n;
    xfer_state_t xfer;
    logic [4:0] hold_cnt;
  } sys_state_t;

  typedef struct packed {
    logic done_tgl;
    logic start_tgl;
    shift_state_t st;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic data;
  } link_state_t;

  sys_state_t s_q;
  sys_state_t s_d;
  link_state_t l_q;
  link_state_t l_d;
  logic [19:0] port_mask;
  logic key_valid;
  logic [7:0] new_code;

  // Mask of ports in use, one bit per port below NUM_PORTS
  always_comb begin
    port_mask = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_mask[p] = 1'b1;
    end
  end

  // Key code encoding and acceptance
  always_comb begin
    new_code = '0;
    new_code[CODE_RELEASE_BIT] = key_release_i;
    new_code[CODE_ROW_LSB +: CODE_ROW_W] = key_row_i;
    new_code[CODE_COL_W - 1:0] = key_col_i + CODE_COL_OFFSET;
    key_valid = key_event_i && (32'(key_col_i) < NUM_COLS) && (32'(key_row_i) < NUM_ROWS) &&
                !ghost_triple(key_matrix_i);
  end

  // System-domain next state
  always_comb begin
    logic start_seen;
    logic done_seen;
    logic take_key;
    start_seen = 1'b0;
    done_seen = 1'b0;
    take_key = 1'b0;
    s_d = s_q;
    // Pin and link toggle synchronisers
    s_d.gpio_s1 = gpio_pin_i;
    s_d.gpio_s2 = s_q.gpio_s1;
    s_d.sel_s1 = host_link_select_i;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.start_s1 = l_q.start_tgl;
    s_d.start_s2 = s_q.start_s1;
    s_d.start_s3 = s_q.start_s2;
    s_d.done_s1 = l_q.done_tgl;
    s_d.done_s2 = s_q.done_s1;
    s_d.done_s3 = s_q.done_s2;
    start_seen = s_q.start_s2 != s_q.start_s3;
    done_seen = s_q.done_s2 != s_q.done_s3;

    // GPIO drive updated only by the write acknowledge
    if (gpio_write_ack_i && !s_q.sel_s2) begin
      s_d.pin_out = gpio_write_data_i & port_mask;
      s_d.pin_oe_n = ~(port_direction_i & port_mask);
    end

    // Sample input ports at read address acknowledge; outputs keep theirs
    if (read_addr_ack_i && !s_q.sel_s2) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_mask[p] && !port_direction_i[p]) begin
          s_d.piv[p] = s_q.gpio_s2[p];
        end
      end
    end

    // Key code holding register with non-empty and overflow flags
    if (key_code_read_i && !s_q.sel_s2) begin
      s_d.key_pending = 1'b0;
      s_d.key_overflow = 1'b0;
    end
    if (key_valid) begin
      if (s_q.key_pending && !(key_code_read_i && !s_q.sel_s2)) begin
        s_d.key_overflow = 1'b1;
      end else if (s_q.xfer == XFER_IDLE) begin
        take_key = 1'b1;
        s_d.key_code = new_code;
        s_d.key_pending = 1'b1;
      end else begin
        s_d.key_overflow = 1'b1;
      end
    end

    // Two-wire interrupt from port change; three-wire from key events
    if (!s_q.sel_s2) begin
      s_d.irq_n = ~(|((s_q.gpio_s2 ^ s_q.piv) & port_change_irq_enable_i &
                      ~port_direction_i & port_mask));
      s_d.xfer = XFER_IDLE;
      s_d.data_oe_n = 1'b1;
    end else begin
      case (s_q.xfer)
        XFER_IDLE: begin
          s_d.irq_n = 1'b1;
          if (take_key) begin
            s_d.link_code = new_code;
            s_d.req_tgl = ~s_q.req_tgl;
            s_d.irq_n = 1'b0;
            s_d.xfer = XFER_WAIT;
          end
        end
        XFER_WAIT: begin
          if (start_seen) begin
            s_d.data_oe_n = 1'b0;
          end
          if (done_seen) begin
            s_d.hold_cnt = HOLD_LOAD;
            s_d.xfer = XFER_HOLD;
          end
        end
        XFER_HOLD: begin
          if (s_q.hold_cnt == 5'h00) begin
            s_d.irq_n = 1'b1;
            s_d.data_oe_n = 1'b1;
            s_d.key_pending = 1'b0;
            s_d.xfer = XFER_IDLE;
          end else begin
            s_d.hold_cnt = s_q.hold_cnt - 5'h01;
          end
        end
        default: begin
          s_d.xfer = XFER_IDLE;
        end
      endcase
    end
  end

  // System-domain registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.pin_oe_n <= 20'hFFFFF;
      s_q.piv <= PORT_INPUT_VALUE_RESET;
      s_q.irq_n <= 1'b1;
      s_q.data_oe_n <= 1'b1;
      s_q.xfer <= XFER_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Link-domain next state: start bit, eight code bits, trailing zero
  // Request toggle read directly: a stopped link clock cannot move a synchroniser,
  // and the host clocks only after the interrupt, launched with the toggle
  always_comb begin
    l_d = l_q;
    case (l_q.st)
      SHIFT_IDLE: begin
        if ((s_q.req_tgl != l_q.done_tgl) && !link_data_i) begin
          l_d.data = s_q.link_code[CODE_BITS - 1];
          l_d.shift = {s_q.link_code[CODE_BITS - 2:0], 1'b0};
          l_d.cnt = 4'h1;
          l_d.start_tgl = ~l_q.start_tgl;
          l_d.st = SHIFT_RUN;
        end
      end
      SHIFT_RUN: begin
        l_d.data = l_q.shift[CODE_BITS - 1];
        l_d.shift = {l_q.shift[CODE_BITS - 2:0], 1'b0};
        l_d.cnt = l_q.cnt + 4'h1;
        if (l_q.cnt == LINK_LAST_COUNT) begin
          l_d.done_tgl = s_q.req_tgl;
          l_d.st = SHIFT_IDLE;
        end
      end
      default: begin
        l_d.st = SHIFT_IDLE;
      end
    endcase
  end

  // Link-domain registers on the host's clock
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      l_q <= '0;
      l_q.st <= SHIFT_IDLE;
    end else begin
      l_q <= l_d;
    end
  end

  // Outputs straight from flip-flops
  assign gpio_pin_o = s_q.pin_out;
  assign gpio_pin_oe_n_o = s_q.pin_oe_n;
  assign port_input_value_o = s_q.piv;
  assign key_code_o = s_q.key_code;
  assign key_pending_o = s_q.key_pending;
  assign key_overflow_o = s_q.key_overflow;
  assign event_irq_n_o = s_q.irq_n;
  assign link_data_o = l_q.data;
  assign link_data_oe_n_o = s_q.data_oe_n;

endmodule

//--- logic/key_encoder_pkg.sv
/*
  Shared constants and state types for the key encoder host port.
  Assumes a 10 MHz system clock; all times are turned into cycles here.
*/
package key_encoder_pkg;

  // Matrix and port geometry
  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 12;
  localparam int NUM_PORTS = 20;

  // Key code field layout
  localparam int CODE_BITS = 8;
  localparam int CODE_RELEASE_BIT = 7;
  localparam int CODE_ROW_LSB = 4;
  localparam int CODE_ROW_W = 3;
  localparam int CODE_COL_W = 4;
  localparam logic [3:0] CODE_COL_OFFSET = 4'h1;

  // Reset value of the port input value bits (low eight ports read high)
  localparam logic [19:0] PORT_INPUT_VALUE_RESET = 20'h000FF;

  // Three-wire link: clock edges after the start bit (code bits six to zero plus trailing zero)
  localparam logic [3:0] LINK_LAST_COUNT = 4'h8;

  // Hold of the data line before the interrupt line returns high
  localparam int CLK_PERIOD_NS = 100;
  localparam int IRQ_END_HOLD_NS = 1350;
  localparam int IRQ_END_HOLD_CYC = (IRQ_END_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HOLD_LOAD = 5'(IRQ_END_HOLD_CYC - 1);

  // System-side progress of one three-wire key code delivery
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_WAIT = 2'b01,
    XFER_HOLD = 2'b10
  } xfer_state_t;

  // Link-side shifter
  typedef enum logic [0:0] {
    SHIFT_IDLE = 1'b0,
    SHIFT_RUN = 1'b1
  } shift_state_t;

endpackage

//--- tb/key_encoder_monitor.sv
/* Port checker for the key encoder host port.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ns
module key_encoder_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic host_link_select_i,
  input wire logic [19:0] port_direction_i,
  input wire logic gpio_write_ack_i,
  input wire logic [19:0] gpio_write_data_i,
  input wire logic read_addr_ack_i,
  input wire logic [19:0] gpio_pin_o,
  input wire logic [19:0] gpio_pin_oe_n_o,
  input wire logic [19:0] port_input_value_o,
  input wire logic key_event_i,
  input wire logic key_release_i,
  input wire logic [2:0] key_row_i,
  input wire logic [3:0] key_col_i,
  input wire logic [7:0] key_code_o,
  input wire logic event_irq_n_o,
  input wire logic link_data_oe_n_o
);
  logic [2:0] sel_q;
  wire sel_ok = (sel_q == 3'h0) && !host_link_select_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Select history, busy until the synchroniser has settled
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) sel_q <= 3'h7;
    else sel_q <= {sel_q[1:0], host_link_select_i};
  end
  AST_WRITE_OE: assert property (sel_ok && gpio_write_ack_i |=> gpio_pin_oe_n_o == ~$past(port_direction_i))
    else $error("output enable wrong after write");
  AST_WRITE_VAL: assert property (sel_ok && gpio_write_ack_i |=> (gpio_pin_o & $past(port_direction_i))
    == ($past(gpio_write_data_i) & $past(port_direction_i))) else $error("pin value wrong after write");
  AST_GPO_HOLD: assert property (!gpio_write_ack_i |=> $stable(gpio_pin_o) && $stable(gpio_pin_oe_n_o))
    else $error("pins moved without write");
  AST_PIV_HOLD: assert property (!read_addr_ack_i |=> $stable(port_input_value_o))
    else $error("input value moved without read");
  AST_PIV_OUT: assert property (sel_ok && read_addr_ack_i |=> ((port_input_value_o ^ $past(port_input_value_o))
    & $past(port_direction_i)) == 20'h0) else $error("output port value changed");
  AST_CODE_FMT: assert property ($changed(key_code_o) |-> $past(key_event_i) && key_code_o ==
    {$past(key_release_i), $past(key_row_i), $past(key_col_i) + 4'h1}) else $error("bad key code");
  AST_IRQ_END: assert property ($rose(link_data_oe_n_o) |-> $rose(event_irq_n_o))
    else $error("interrupt not released with data");
  AST_OE_IRQ: assert property (!link_data_oe_n_o |-> !event_irq_n_o && host_link_select_i)
    else $error("data driven outside request");
  cover property (!link_data_oe_n_o);
  cover property (sel_ok && $fell(event_irq_n_o));
  cover property (sel_ok && read_addr_ack_i);
endmodule
bind key_matrix_encoder_host_port key_encoder_monitor key_encoder_monitor_inst (.*);

//--- tb/link_host_model.sv
/* Host side of the three-wire key code link.
   Clock idles low between frames; released data line reads high (pull-up). */
`timescale 1ns/1ns
module link_host_model (
  input wire logic sel_i,
  input wire logic irq_n_i,
  input wire logic oe_n_i,
  input wire logic data_i,
  output logic clk_o,
  output logic drv_o,
  output logic [8:0] bits_o,
  output int frames_o
);
  // One frame per falling interrupt
  initial begin
    clk_o = 1'b0;
    drv_o = 1'b1;
    bits_o = 9'h000;
    frames_o = 0;
    forever begin
      @(negedge irq_n_i iff sel_i);
      #100 drv_o = 1'b0;
      #24 clk_o = 1'b1;
      #24 clk_o = 1'b0;
      wait (!oe_n_i);
      drv_o = 1'b1;
      #1 bits_o = {bits_o[7:0], data_i};
      repeat (8) begin
        #23 clk_o = 1'b1;
        #1 bits_o = {bits_o[7:0], data_i};
        #24 clk_o = 1'b0;
      end
      frames_o++;
    end
  end
endmodule

//--- tb/tb.sv
/* Self-checking bench for the key encoder host port.
   Bench plays the two-wire engine and scanner; a host model clocks the link. */
`timescale 1ns/1ns
module tb;
  import key_encoder_pkg::*;
  logic clk, rst, sel, wack, rack, rrd, kev, krel, krd, lclk, hdrv, ldo, loen, irqn, kpend, kovf, rl;
  logic [2:0] r;
  logic [3:0] c;
  logic [2:0] krow;
  logic [3:0] kcol;
  logic [7:0] kcode;
  logic [8:0] bits;
  logic [19:0] pin, dir, en, wdat, gpo, oen, piv, pv, d, m;
  logic [95:0] kmat;
  int bad_count, n_checks, frames, f;
  wire lwire = loen ? hdrv : ldo;

  key_matrix_encoder_host_port key_matrix_encoder_host_port_inst (
    .sys_clk_i(clk), .sys_rst_i(rst), .link_clk_i(lclk), .host_link_select_i(sel),
    .gpio_pin_i(pin), .gpio_pin_o(gpo), .gpio_pin_oe_n_o(oen), .port_direction_i(dir),
    .port_change_irq_enable_i(en), .gpio_write_ack_i(wack), .gpio_write_data_i(wdat),
    .read_addr_ack_i(rack), .port_input_value_read_i(rrd), .port_input_value_o(piv),
    .key_event_i(kev), .key_release_i(krel), .key_row_i(krow), .key_col_i(kcol), .key_matrix_i(kmat),
    .key_code_read_i(krd), .key_code_o(kcode), .key_pending_o(kpend), .key_overflow_o(kovf),
    .event_irq_n_o(irqn), .link_data_i(lwire), .link_data_o(ldo), .link_data_oe_n_o(loen));
  link_host_model link_host_model_inst (.sel_i(sel), .irq_n_i(irqn), .oe_n_i(loen), .data_i(lwire),
    .clk_o(lclk), .drv_o(hdrv), .bits_o(bits), .frames_o(frames));

  // System clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog
  initial begin
    #3000000;
    bad_count++;
    give_verdict();
  end

  function automatic logic [7:0] exp_code(logic rel, logic [2:0] rw, logic [3:0] cl);
    return {rel, rw, cl + 4'h1};
  endfunction
  function automatic logic [19:0] exp_piv(logic [19:0] old, p, dr);
    return (p & ~dr) | (old & dr);
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(logic [19:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic key(logic rel, logic [2:0] rw, logic [3:0] cl, logic [95:0] mx);
    krel <= rel;
    krow <= rw;
    kcol <= cl;
    kmat <= mx;
    kev <= 1'b1;
    tick(1);
    kev <= 1'b0;
    tick(1);
  endtask
  task automatic rd_key();
    krd <= 1'b1;
    tick(1);
    krd <= 1'b0;
    tick(1);
  endtask
  task automatic pulse_read();
    rack <= 1'b1;
    tick(1);
    rack <= 1'b0;
    rrd <= 1'b1;
    tick(1);
    rrd <= 1'b0;
    tick(1);
  endtask
  task automatic wirq(logic v, int n);
    for (int i = 0; i < n && irqn !== v; i++) tick(1);
    cmp(irqn, v);
  endtask

  // Main sequence
  initial begin
    {rst, sel, wack, rack, rrd, kev, krel, krd} = 8'h80;
    {pin, dir, en, wdat, krow, kcol, kmat} = '0;
    pv = PORT_INPUT_VALUE_RESET;
    void'($urandom(27728));
    tick(6);
    rst <= 1'b0;
    tick(3);
    cmp(oen, 20'hFFFFF);
    cmp(piv, pv);
    cmp(irqn, 1'b1);
    repeat (4) begin
      d = 20'($urandom);
      m = 20'($urandom);
      dir <= m;
      wdat <= d;
      wack <= 1'b1;
      tick(1);
      wack <= 1'b0;
      wdat <= ~d;
      tick(2);
      cmp(oen, ~m);
      cmp(gpo & m, d & m);
    end
    repeat (3) begin
      pin <= 20'($urandom);
      tick(3);
      pulse_read();
      pv = exp_piv(pv, pin, m);
      cmp(piv, pv);
    end
    // Ports 4-7 monitored inputs, port 2 an enabled output
    dir <= 20'h0000F;
    en <= 20'h000F4;
    pin <= 20'h0;
    tick(3);
    pulse_read();
    wirq(1'b1, 4);
    pin <= 20'h00104;
    tick(8);
    cmp(irqn, 1'b1);
    pin <= 20'h00124;
    wirq(1'b0, 6);
    pulse_read();
    wirq(1'b1, 4);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
      c = (i == 0) ? 4'hB : (i == 1) ? 4'h0 : 4'($urandom % 12);
      rl = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
      key(rl, r, c, rl ? 96'h0 : 96'h1 << (r * 12 + c));
      cmp(kcode, exp_code(rl, r, c));
      cmp(kpend, 1'b1);
      rd_key();
      cmp(kpend, 1'b0);
    end
    key(1'b0, 3'h2, 4'h5, 96'h0);
    key(1'b1, 3'h3, 4'h6, 96'h0);
    cmp(kcode, exp_code(1'b0, 3'h2, 4'h5));
    cmp(kovf, 1'b1);
    rd_key();
    cmp(kovf, 1'b0);
    key(1'b0, 3'h1, 4'h0, 96'h1003);
    cmp(kpend, 1'b0);
    key(1'b0, 3'h0, 4'hB, 96'hFFF);
    cmp(kcode, exp_code(1'b0, 3'h0, 4'hB));
    rd_key();
    // Three-wire mode, select fixed under reset
    sel <= 1'b1;
    en <= 20'h00000;
    rst <= 1'b1;
    tick(6);
    rst <= 1'b0;
    tick(3);
    wack <= 1'b1;
    tick(1);
    wack <= 1'b0;
    tick(2);
    cmp(oen, 20'hFFFFF);
    for (int i = 0; i < 3; i++) begin
      r = 3'($urandom);
      c = 4'($urandom % 12);
      rl = 1'($urandom);
      f = frames;
      key(rl, r, c, 96'h0);
      cmp(irqn, 1'b0);
      for (int j = 0; j < 200 && frames == f; j++) tick(1);
      cmp(bits, {exp_code(rl, r, c), 1'b0});
      wirq(1'b1, 30);
    end
    give_verdict();
  end
endmodule
